// file: inc/ipi_params.svh
// constants for the isa card pin interface
// assumes inclusion from the package and design files only
`ifndef IPI_PARAMS_SVH
`define IPI_PARAMS_SVH
`define IPI_ADDR_W 16
`define IPI_DATA_W 8
`define IPI_DRQ_N 4
`define IPI_DACK_N 5
`define IPI_IRQ_N 7
`define IPI_LA_W 8
`define IPI_REG_N 8
`define IPI_REG_AW 3
`define IPI_REG_AW_BITS 3'h0
`define IPI_BASE_DEF 16'h0220
`define IPI_BASE_MASK 16'hFFF8
// read strobe, write strobe and aen (low three synchroniser bits) idle high
`define IPI_SYNC_IDLE 3'h7
// latched address input bits that carry the acknowledges in dma mode
`define IPI_DACK6_BIT 0
`define IPI_DACK0_BIT 2
`define IPI_DACK3_BIT 4
`define IPI_DACK5_BIT 6
`endif

// file: inc/ipi_pkg.sv
// types shared by the isa card pin interface
// assumes ipi_params.svh is on the include path
`include "ipi_params.svh"
package ipi_pkg;
  typedef enum logic [1:0] {
    IPI_MODE_MEM = 2'h1,
    IPI_MODE_DMA = 2'h2
  } ipi_mode_t;
  typedef enum logic [2:0] {
    IPI_ST_WAIT_KEY = 3'h1,
    IPI_ST_SLEEP = 3'h2,
    IPI_ST_CONFIG = 3'h4
  } ipi_state_t;
endpackage

// file: core/ipi_regfile.sv
// small register store for the card's i/o window
// assumes one clock, synchronous active-high reset, registered read data
`include "ipi_params.svh"
module ipi_regfile #(
  parameter int DEPTH = `IPI_REG_N,
  parameter int AW = `IPI_REG_AW
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wrEn,
  input wire logic [AW-1:0] addr,
  input wire logic [`IPI_DATA_W-1:0] wrData,
  output logic [`IPI_DATA_W-1:0] rdData
);
  logic [`IPI_DATA_W-1:0] mem_reg [DEPTH];
  logic [`IPI_DATA_W-1:0] mem_next [DEPTH];
  logic [`IPI_DATA_W-1:0] rd_reg;
  logic [`IPI_DATA_W-1:0] rd_next;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (wrEn) begin
      mem_next[addr] = wrData;
    end
    rd_next = mem_reg[addr];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      rd_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      rd_reg <= rd_next;
    end
  end

  assign rdData = rd_reg;
endmodule // ipi_regfile

// file: core/ipi_bus_if.sv
// isa host bus pin interface of a plug and play card controller
// assumes bus pins are asynchronous to clk; tristate resolution done outside
//
// Behaviour
// - bus reset clears registers and latched address, presets synchronisers to idle strobes and aen high, and enters wait-for-key state
// - slash-named signals are active low, all others active high
// - low sixteen address lines come straight from the host bus
// - shared pin is address bit 16 in memory mode, dack6 in dma mode
// - in dma mode latched address 17,19,21,23 pins drive dreq 0,3,5,6
// - dma request pins not assigned as outputs stay high impedance
// - latched address 18,20,22 pins become dack 0,3,5 in dma mode
// - bale qualifies address latching in memory mode; dack7 in dma mode
// - all transfers use the eight-bit bidirectional data bus
// - a cycle is an i/o read only while the read strobe is low
// - a cycle is an i/o write only while the write strobe is low
// - i/o cycles are ignored while aen is high
// - irq outputs for 3,4,5,7,10,11,12; unassigned ones stay high impedance
// - dma mode gives dma requests; memory mode gives memory selects instead
`include "ipi_params.svh"
module ipi_bus_if #(
  parameter logic [`IPI_ADDR_W-1:0] BASE_ADDR = `IPI_BASE_DEF,
  parameter logic [`IPI_ADDR_W-1:0] BASE_MASK = `IPI_BASE_MASK
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic dmaMode,
  input wire logic [`IPI_ADDR_W-1:0] sysAddr,
  input wire logic [`IPI_LA_W-1:0] latAddrIn,
  input wire logic baleIn,
  input wire logic ioRead_n,
  input wire logic ioWrite_n,
  input wire logic addrEnable,
  input wire logic [`IPI_DATA_W-1:0] sdIn,
  output logic [`IPI_DATA_W-1:0] sdOut,
  output logic sdOe,
  input wire logic [`IPI_DRQ_N-1:0] drqReq,
  input wire logic [`IPI_DRQ_N-1:0] drqAssign,
  output logic [`IPI_DRQ_N-1:0] drqOut,
  output logic [`IPI_DRQ_N-1:0] drqOe,
  output logic [`IPI_DACK_N-1:0] dackActive,
  input wire logic [`IPI_IRQ_N-1:0] irqReq,
  input wire logic [`IPI_IRQ_N-1:0] irqAssign,
  output logic [`IPI_IRQ_N-1:0] irqOut,
  output logic [`IPI_IRQ_N-1:0] irqOe,
  output logic memSelActive,
  output logic [`IPI_LA_W-1:0] latchedAddr,
  output logic [2:0] cfgState
);
  // ************************************
  // pin synchronisers
  // ************************************
  localparam int SW = `IPI_ADDR_W + `IPI_LA_W + `IPI_DATA_W + 4;
  logic [SW-1:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic [`IPI_ADDR_W-1:0] addrS;
  logic [`IPI_LA_W-1:0] laS;
  logic [`IPI_DATA_W-1:0] sdS;
  logic baleS, iorS_n, iowS_n, aenS;
  logic iowPrev_reg, iowPrev_next;
  // synchronisers leave reset showing idle strobes and aen high, so no phantom cycle follows reset
  localparam logic [SW-1:0] SYNC_IDLE = SW'(`IPI_SYNC_IDLE);

  always_comb begin
    sync1_next = {sysAddr, latAddrIn, sdIn, baleIn, ioRead_n, ioWrite_n, addrEnable};
    sync2_next = sync1_reg;
    iowPrev_next = iowS_n;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
      iowPrev_reg <= 1'h1;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      iowPrev_reg <= iowPrev_next;
    end
  end

  assign {addrS, laS, sdS, baleS, iorS_n, iowS_n, aenS} = sync2_reg;

  // ************************************
  // cycle decode
  // ************************************
  logic hit, rdCyc, wrStrobe;
  logic [`IPI_DATA_W-1:0] rdData;
  logic [`IPI_LA_W-1:0] la_reg, la_next;
  ipi_pkg::ipi_state_t st_reg, st_next;

  assign hit = !aenS && ((addrS & BASE_MASK) == (BASE_ADDR & BASE_MASK));
  assign rdCyc = hit && !iorS_n;
  // write taken once, on the strobe's falling edge
  assign wrStrobe = hit && !iowS_n && iowPrev_reg;

  ipi_regfile #(.DEPTH(`IPI_REG_N), .AW(`IPI_REG_AW)) u_regs (
    .clk(clk),
    .reset(reset),
    .wrEn(wrStrobe),
    .addr(addrS[`IPI_REG_AW-1:0]),
    .wrData(sdS),
    .rdData(rdData)
  );

  // ************************************
  // latched address, config state, data drive
  // ************************************
  logic sdOe_reg, sdOe_next;

  always_comb begin
    la_next = la_reg;
    if (!dmaMode && baleS) begin
      la_next = laS;
    end
    st_next = st_reg;
    case (st_reg)
      ipi_pkg::IPI_ST_WAIT_KEY: if (wrStrobe) st_next = ipi_pkg::IPI_ST_SLEEP;
      ipi_pkg::IPI_ST_SLEEP: if (wrStrobe) st_next = ipi_pkg::IPI_ST_CONFIG;
      ipi_pkg::IPI_ST_CONFIG: st_next = ipi_pkg::IPI_ST_CONFIG;
      default: st_next = ipi_pkg::IPI_ST_WAIT_KEY;
    endcase
    sdOe_next = rdCyc;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      la_reg <= '0;
      st_reg <= ipi_pkg::IPI_ST_WAIT_KEY;
      sdOe_reg <= 1'h0;
    end else begin
      la_reg <= la_next;
      st_reg <= st_next;
      sdOe_reg <= sdOe_next;
    end
  end

  // release follows the strobe quickly: gate the registered enable with the live decode
  assign sdOe = sdOe_reg && rdCyc;
  // store's own output register: another stage here would show the previous address's byte first
  assign sdOut = rdData;
  assign cfgState = st_reg;
  assign latchedAddr = la_reg;
  assign memSelActive = !dmaMode;

  // ************************************
  // dual function pins
  // ************************************
  // dack order {7,6,5,3,0}: 0,3,5 on la18/20/22, 6 on sa16, 7 on bale
  assign dackActive = dmaMode ? {!baleS, !laS[`IPI_DACK6_BIT], !laS[`IPI_DACK5_BIT], !laS[`IPI_DACK3_BIT],
    !laS[`IPI_DACK0_BIT]} : '0;

  genvar g;
  generate
    for (g = 0; g < `IPI_DRQ_N; g++) begin : g_drq
      assign drqOe[g] = dmaMode && drqAssign[g];
      assign drqOut[g] = drqOe[g] && drqReq[g];
    end
    for (g = 0; g < `IPI_IRQ_N; g++) begin : g_irq
      assign irqOe[g] = irqAssign[g];
      assign irqOut[g] = irqAssign[g] && irqReq[g];
    end
  endgenerate

  // ************************************
  // checks
  // ************************************
  property p_reset_wait;
    @(posedge clk) reset |=> (st_reg == ipi_pkg::IPI_ST_WAIT_KEY && !sdOe);
  endproperty
  a_reset_wait: assert property (p_reset_wait) else $error("not in wait-for-key after reset");

  property p_rd_drive;
    @(posedge clk) disable iff (reset) sdOe |-> (!$past(ioRead_n, 2) && !$past(addrEnable, 2));
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("data driven outside own read");

  property p_aen_ignore;
    @(posedge clk) disable iff (reset) $past(addrEnable, 2) |-> (!wrStrobe && !sdOe);
  endproperty
  a_aen_ignore: assert property (p_aen_ignore) else $error("responded while aen high");

  property p_rd_latency;
    @(posedge clk) disable iff (reset) (rdCyc && $past(rdCyc)) |-> sdOe;
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read not driven");

  property p_wr_once;
    @(posedge clk) disable iff (reset) wrStrobe |=> !wrStrobe;
  endproperty
  a_wr_once: assert property (p_wr_once) else $error("write taken twice");

  property p_drq_z;
    @(posedge clk) disable iff (reset) !dmaMode |-> (drqOe == '0 && drqOut == '0);
  endproperty
  a_drq_z: assert property (p_drq_z) else $error("dma request driven in memory mode");

  property p_irq_z;
    @(posedge clk) disable iff (reset) (irqOut & ~irqOe) == '0;
  endproperty
  a_irq_z: assert property (p_irq_z) else $error("irq asserted while released");

  property p_bale_latch;
    @(posedge clk) disable iff (reset) (!dmaMode && baleS) |=> (la_reg == $past(laS));
  endproperty
  a_bale_latch: assert property (p_bale_latch) else $error("address not latched on bale");

  property p_dack_mem;
    @(posedge clk) disable iff (reset) !dmaMode |-> dackActive == '0;
  endproperty
  a_dack_mem: assert property (p_dack_mem) else $error("dack seen in memory mode");

  property p_sd_stable;
    @(posedge clk) disable iff (reset) (sdOe && $past(sdOe)) |-> $stable(sdOut);
  endproperty
  a_sd_stable: assert property (p_sd_stable) else $error("read data changed while driven");

  c_read: cover property (@(posedge clk) disable iff (reset) sdOe);
  c_write: cover property (@(posedge clk) disable iff (reset) wrStrobe);
  c_cfg: cover property (@(posedge clk) disable iff (reset) st_reg == ipi_pkg::IPI_ST_CONFIG);
  c_drq: cover property (@(posedge clk) disable iff (reset) drqOut != '0);
  c_dack: cover property (@(posedge clk) disable iff (reset) dackActive != '0);
endmodule // ipi_bus_if

// file: tb/ipi_host_model.sv
// isa host bus model: address, strobes, aen and the shared data lines
// assumes busCycle is called just after a falling edge of clk
module ipi_host_model (
  input wire logic clk,
  input wire logic [7:0] sdOut,
  input wire logic sdOe,
  output logic [15:0] sysAddr,
  output logic ioRead_n,
  output logic ioWrite_n,
  output logic addrEnable,
  output logic [7:0] sdIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv;
  logic [7:0] dat;
  // released lines show the inverse of the last value so stale data never matches
  assign sdIn = sdOe ? sdOut : (drv ? dat : ~dat);
  initial begin
    sysAddr = 16'h0000;
    ioRead_n = 1'b1;
    ioWrite_n = 1'b1;
    addrEnable = 1'b1;
    drv = 1'b0;
    dat = 8'h00;
  end
  task automatic busCycle(input logic [15:0] a, input logic [7:0] d, input logic wr, input logic aen);
    sysAddr = a;
    addrEnable = aen;
    dat = d;
    drv = wr;
    ioWrite_n = !wr;
    ioRead_n = wr;
    repeat (5) @(negedge clk);
    ioWrite_n = 1'b1;
    ioRead_n = 1'b1;
    drv = 1'b0;
    repeat (3) @(negedge clk);
    addrEnable = 1'b1;
    // one idle edge with aen high, so a following call never reassigns it in the same step
    @(negedge clk);
  endtask
endmodule // ipi_host_model

// file: tb/testbench.sv
// self-checking bench for the isa card pin interface
// assumes ipi_bus_if at its default window 0x0220, eight bytes
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, dmaMode, baleIn, ioRead_n, ioWrite_n, addrEnable, sdOe, memSelActive, oePrev;
  logic [15:0] sysAddr;
  logic [7:0] sdIn, sdOut, latAddrIn, latchedAddr, v;
  logic [3:0] drqReq, drqAssign, drqOut, drqOe;
  logic [4:0] dackActive;
  logic [6:0] irqReq, irqAssign, irqOut, irqOe;
  logic [2:0] cfgState;
  logic [7:0] expQ[$];
  logic [7:0] mem[8];
  int failures, check_count, seed, i;
  ipi_bus_if ipi_bus_if_i (.clk, .reset, .dmaMode, .sysAddr, .latAddrIn, .baleIn, .ioRead_n, .ioWrite_n,
    .addrEnable, .sdIn, .sdOut, .sdOe, .drqReq, .drqAssign, .drqOut, .drqOe, .dackActive, .irqReq,
    .irqAssign, .irqOut, .irqOe, .memSelActive, .latchedAddr, .cfgState);
  ipi_host_model ipi_host_model_i (.clk, .sdOut, .sdOe, .sysAddr, .ioRead_n, .ioWrite_n, .addrEnable, .sdIn);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************
  // read monitor
  // ****************
  always @(negedge clk) begin
    if (sdOe === 1'b1 && oePrev !== 1'b1) begin
      if (expQ.size() == 0) chk("unclaimed drive", 8'h00, 8'h01);
      else chk("read data", expQ.pop_front(), sdOut);
    end
    oePrev = sdOe;
  end
  initial begin
    #50000;
    failures++;
    $display("Error watchdog expected done seen timeout");
    summarize();
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    seed = 32'h51CF;
    failures = 0;
    check_count = 0;
    oePrev = 1'b0;
    reset = 1'b1;
    dmaMode = 1'b0;
    baleIn = 1'b0;
    latAddrIn = 8'h00;
    drqReq = 4'h0;
    drqAssign = 4'h0;
    irqReq = 7'h00;
    irqAssign = 7'h00;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    chk("state", 8'h01, 8'(cfgState));
    chk("latched", 8'h00, latchedAddr);
    repeat (3) @(negedge clk);
    for (i = 0; i < 8; i++) begin
      mem[i] = 8'($random(seed));
      ipi_host_model_i.busCycle(16'(16'h0220 + i), mem[i], 1'b1, 1'b0);
      if (i < 2) chk("state", (i == 0) ? 8'h02 : 8'h04, 8'(cfgState));
    end
    // refused writes must leave the store alone
    ipi_host_model_i.busCycle(16'h0221, ~mem[1], 1'b1, 1'b1);
    ipi_host_model_i.busCycle(16'h0229, ~mem[1], 1'b1, 1'b0);
    for (i = 0; i < 8; i++) begin
      expQ.push_back(mem[i]);
      ipi_host_model_i.busCycle(16'(16'h0220 + i), 8'h00, 1'b0, 1'b0);
    end
    ipi_host_model_i.busCycle(16'h0221, 8'h00, 1'b0, 1'b1);
    ipi_host_model_i.busCycle(16'h0228, 8'h00, 1'b0, 1'b0);
    chk("pending reads", 8'h00, 8'(expQ.size()));
    for (i = 0; i < 20; i++) begin
      dmaMode = i[0];
      drqReq = 4'($random(seed));
      drqAssign = 4'($random(seed));
      irqReq = 7'($random(seed));
      irqAssign = 7'($random(seed));
      latAddrIn = 8'($random(seed));
      baleIn = i[0] ? 1'($random(seed)) : 1'b1;
      repeat (4) @(negedge clk);
      chk("dreq enable", 8'(drqAssign & {4{dmaMode}}), 8'(drqOe));
      chk("dreq level", 8'(drqReq & drqAssign & {4{dmaMode}}), 8'(drqOut & drqAssign & {4{dmaMode}}));
      chk("irq enable", 8'(irqAssign), 8'(irqOe));
      chk("irq level", 8'(irqReq & irqAssign), 8'(irqOut & irqAssign));
      chk("dack", dmaMode ? 8'({~baleIn, ~latAddrIn[0], ~latAddrIn[6], ~latAddrIn[4], ~latAddrIn[2]}) : 8'h00,
        8'(dackActive));
      chk("mem select", 8'(!dmaMode), 8'(memSelActive));
      if (!dmaMode) begin
        v = latAddrIn;
        baleIn = 1'b0;
        repeat (3) @(negedge clk);
        latAddrIn = ~v;
        repeat (4) @(negedge clk);
        chk("latched", v, latchedAddr);
      end
    end
    // a second reset in mid-run clears state and store
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    chk("state", 8'h01, 8'(cfgState));
    repeat (3) @(negedge clk);
    expQ.push_back(8'h00);
    ipi_host_model_i.busCycle(16'h0223, 8'h00, 1'b0, 1'b0);
    chk("pending reads", 8'h00, 8'(expQ.size()));
    summarize();
  end
endmodule // testbench
